// File: src/four_to_two_space_remapper.sv
// four-space to two-space partition label remapper with its bus-reached control registers
//
// Behaviour
// - root request: outgoing one-bit label comes from control bit 15
// - root request: control bit 14 drives the monitor suppress flag
// - realm request: outgoing one-bit label comes from control bit 7
// - realm request: control bit 6 drives the monitor suppress flag
// - control register reachable only by root address space accesses; others denied
// - accept four-space labels, remap only root and realm, forward downstream
// - fixed mode: outgoing label equals bit 0 of incoming label
// - downstream without a suppress input leaves the flag unconnected
// - components without partition support get requests with partition info stripped
// - stripped requests carry all-zero partition info, never forwarded labels
// - physical address space of each request passes through unchanged
// - secure and non-secure requests keep their own space; strip mode sends label 0 for both
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps

module four_to_two_space_remapper import remap_pkg::*; #(
  parameter int PART_ID_W = PART_ID_WIDTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register bus, AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [1:0] hpas,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // incoming four-space request
  input wire logic req_valid,
  input wire logic [1:0] four_space_label_in,
  input wire logic [PART_ID_W-1:0] req_partition_identifier,
  input wire logic [1:0] req_pas,
  // outgoing two-space request
  output logic out_valid,
  output logic two_space_label_out,
  output logic monitor_suppress_flag,
  output logic [PART_ID_W-1:0] out_partition_identifier,
  output logic [1:0] out_pas
);

  // register state
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic [CTRL_WIDTH-1:0] ctrl_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic denied_reg;
  logic denied_next;
  logic remap_seen_reg;
  logic remap_seen_next;

  // data phase bookkeeping
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;

  // address phase decode, plus the data phase write strobes for the pending write
  wire addr_phase = hsel & (htrans == HTRANS_NONSEQ) & hready;
  wire from_root = (hpas == SPACE_ROOT);
  wire access_ok = addr_phase & from_root;
  wire access_denied = addr_phase & ~from_root;
  wire wr_go = wr_pend_reg & hready;
  wire wr_ctrl = wr_go & (wr_addr_reg == CTRL_OFFSET);
  wire wr_mode = wr_go & (wr_addr_reg == MODE_OFFSET);
  wire wr_status = wr_go & (wr_addr_reg == STATUS_OFFSET);
  wire rd_go = access_ok & ~hwrite;

  // next register values; the read mux looks at these so a read right after a write sees it
  assign ctrl_next = wr_ctrl ? (hwdata[CTRL_WIDTH-1:0] & CTRL_WRITE_MASK) : ctrl_reg;
  assign mode_next = wr_mode ? hwdata[1:0] : mode_reg;

  // request classification
  wire is_root = (four_space_label_in == SPACE_ROOT);
  wire is_realm = (four_space_label_in == SPACE_REALM);
  wire fixed_mode = mode_reg[MODE_FIXED_BIT];
  wire strip_mode = mode_reg[MODE_STRIP_BIT];
  wire remap_event = req_valid & (is_root | is_realm) & ~fixed_mode & ~strip_mode;

  // sticky flags: a set in the same cycle as a write-one clear wins
  assign denied_next = access_denied
    | (denied_reg & ~(wr_status & hwdata[STATUS_DENIED_BIT]));
  assign remap_seen_next = remap_event
    | (remap_seen_reg & ~(wr_status & hwdata[STATUS_REMAP_BIT]));

  // programmable mapping; secure and non-secure keep their own bit
  wire prog_label = is_root ? ctrl_reg[ROOT_SPACE_BIT] :
                    is_realm ? ctrl_reg[REALM_SPACE_BIT] :
                    four_space_label_in[0];
  wire prog_nomon = is_root ? ctrl_reg[ROOT_NOMON_BIT] :
                    is_realm ? ctrl_reg[REALM_NOMON_BIT] :
                    1'b0;

  // mode selection, strip overrides fixed, fixed overrides programmable
  wire label_sel = strip_mode ? 1'b0 :
                   fixed_mode ? four_space_label_in[0] :
                   prog_label;
  wire nomon_sel = (strip_mode | fixed_mode) ? 1'b0 : prog_nomon;
  wire [PART_ID_W-1:0] part_id_sel = strip_mode ? '0 : req_partition_identifier;

  // read mux, unmapped offsets and denied reads give zero
  wire [31:0] rd_ctrl = {16'h0000, ctrl_next};
  wire [31:0] rd_mode = {30'h0000_0000, mode_next};
  wire [31:0] rd_status = {30'h0000_0000, remap_seen_next, denied_next};
  wire [31:0] rd_value = (haddr == CTRL_OFFSET) ? rd_ctrl :
                         (haddr == MODE_OFFSET) ? rd_mode :
                         (haddr == STATUS_OFFSET) ? rd_status :
                         32'h0000_0000;

  // bus data phase tracking; only root writes ever reach a register
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_reg <= access_ok & hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // bus answers: always ready, always okay, so every transfer is zero wait
  always_ff @(posedge mclk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= rd_go ? rd_value : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      mode_reg <= MODE_RESET;
      denied_reg <= 1'b0;
      remap_seen_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      denied_reg <= denied_next;
      remap_seen_reg <= remap_seen_next;
    end
  end

  // request stage: one registered cycle so every output leaves a flip-flop;
  // no back-pressure, the downstream side must take one request per cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_valid <= 1'b0;
      two_space_label_out <= 1'b0;
      monitor_suppress_flag <= 1'b0;
      out_partition_identifier <= '0;
      out_pas <= SPACE_SECURE;
    end else begin
      out_valid <= req_valid;
      two_space_label_out <= label_sel;
      monitor_suppress_flag <= nomon_sel;
      out_partition_identifier <= part_id_sel;
      out_pas <= req_pas;
    end
  end

endmodule : four_to_two_space_remapper

// File: src/remap_pkg.sv
// constants shared by the four-space to two-space request remapper
package remap_pkg;

  // register byte offsets on the register bus
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] MODE_OFFSET = 32'h0000_0004;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;

  // field positions in partition_space_remap_control
  localparam int ROOT_SPACE_BIT = 15;
  localparam int ROOT_NOMON_BIT = 14;
  localparam int REALM_SPACE_BIT = 7;
  localparam int REALM_NOMON_BIT = 6;
  localparam int CTRL_WIDTH = 16;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hC0C0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // field positions in the mode register
  localparam int MODE_FIXED_BIT = 0;
  localparam int MODE_STRIP_BIT = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // field positions in the status register
  localparam int STATUS_DENIED_BIT = 0;
  localparam int STATUS_REMAP_BIT = 1;

  // four-space label encodings, also used for the physical address space
  localparam logic [1:0] SPACE_SECURE = 2'h0;
  localparam logic [1:0] SPACE_NONSECURE = 2'h1;
  localparam logic [1:0] SPACE_ROOT = 2'h2;
  localparam logic [1:0] SPACE_REALM = 2'h3;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // default width of the partition identifier
  localparam int PART_ID_WIDTH = 16;

endpackage : remap_pkg

// File: test/remap_assertions.sv
// request path and bus response checker for the remapper
`timescale 1ns/1ps
module remap_assertions import remap_pkg::*; #(parameter int PART_ID_W = 16) (
  // clock, reset and bus response
  input wire logic mclk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  // request strobes, labels and sidebands
  input wire logic req_valid,
  input wire logic out_valid,
  input wire logic two_space_label_out,
  input wire logic monitor_suppress_flag,
  input wire logic [1:0] four_space_label_in,
  input wire logic [1:0] req_pas,
  input wire logic [1:0] out_pas,
  input wire logic [PART_ID_W-1:0] req_partition_identifier,
  input wire logic [PART_ID_W-1:0] out_partition_identifier
);
  // strip mode zeroes label, flag and id together; the mode register is not visible here
  wire stripped = (out_partition_identifier == '0) && !two_space_label_out
    && !monitor_suppress_flag;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_req(logic [1:0] l);
    req_valid && four_space_label_in == l;
  endsequence
  a_out_strobe: assert property (req_valid |=> out_valid) else $error("lost request");
  a_no_spurious: assert property (!req_valid |=> !out_valid) else $error("extra out");
  a_pas_through: assert property (req_valid |=> out_pas == $past(req_pas))
    else $error("pas altered");
  a_part_id_kept: assert property (req_valid |=>
    out_partition_identifier == $past(req_partition_identifier) || stripped)
    else $error("partition id altered");
  a_secure_kept: assert property (s_req(SPACE_SECURE) |=>
    !two_space_label_out && !monitor_suppress_flag) else $error("secure moved");
  a_nonsec_kept: assert property (s_req(SPACE_NONSECURE) |=>
    (two_space_label_out && !monitor_suppress_flag)
    || (stripped && $past(req_partition_identifier) != '0)) else $error("nonsecure moved");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY) else $error("resp");
  a_reset_quiet: assert property ($fell(reset) |-> !out_valid && out_pas == 2'h0)
    else $error("not cleared");
endmodule : remap_assertions
bind four_to_two_space_remapper remap_assertions #(.PART_ID_W(PART_ID_W)) u_chk (.mclk, .reset,
  .hreadyout, .hresp, .req_valid, .out_valid, .two_space_label_out, .monitor_suppress_flag,
  .four_space_label_in, .req_pas, .out_pas, .req_partition_identifier,
  .out_partition_identifier);

// File: test/tb_four_to_two_space_remapper.sv
// bench for the four-space to two-space remapper
`timescale 1ns/1ps
module tb_four_to_two_space_remapper import remap_pkg::*; ();
  logic mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, mode_w;
  logic [1:0] htrans = 2'h0, hpas = 2'h0, lab_in = 2'h0, pas_in = 2'h0, out_pas;
  logic [15:0] pid_in = 16'h0, out_pid, c, e_pid;
  logic hreadyout, hresp, out_valid, lab_out, flag, e_lab, e_flag;
  logic [7:0] mon_count, e_mon = 8'h00;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  // clock and a hang guard well above the 72 cycles needed
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (++cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  four_to_two_space_remapper dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hpas, .hreadyout, .hrdata, .hresp,
    .req_valid, .four_space_label_in(lab_in), .req_partition_identifier(pid_in),
    .req_pas(pas_in), .out_valid, .two_space_label_out(lab_out), .out_pas,
    .monitor_suppress_flag(flag), .out_partition_identifier(out_pid));
  two_space_sink sink (.mclk, .reset, .valid(out_valid), .suppress(flag), .mon_count);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one single word transfer; hready is honoured though the slave has no waits
  task automatic bus(input logic [31:0] a, d, input logic w, input logic [1:0] p);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hpas <= p;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    bus(CTRL_OFFSET, 32'h0, 1'b0, SPACE_ROOT);
    chk("ctrl_rst", 32'(CTRL_RESET), rd);
    bus(CTRL_OFFSET, 32'hFFFF_FFFF, 1'b1, SPACE_ROOT);
    bus(CTRL_OFFSET, 32'h0, 1'b1, SPACE_REALM);
    bus(CTRL_OFFSET, 32'h0, 1'b0, SPACE_SECURE);
    chk("ctrl_deny", 32'h0, rd);
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
    bus(CTRL_OFFSET, 32'h0, 1'b0, SPACE_ROOT);
    chk("ctrl", 32'(CTRL_WRITE_MASK), rd);
    bus(32'h0000_0010, 32'h0, 1'b0, SPACE_ROOT);
    chk("unmapped", 32'h0, rd);
    // the two refused accesses above must have left the sticky denied flag
    bus(STATUS_OFFSET, 32'h0, 1'b0, SPACE_ROOT);
    chk("status_deny", 32'h1 << STATUS_DENIED_BIT, rd);
    bus(STATUS_OFFSET, 32'hFFFF_FFFF, 1'b1, SPACE_ROOT);
    bus(STATUS_OFFSET, 32'h0, 1'b0, SPACE_ROOT);
    chk("status_clr", 32'h0, rd);
    // pass 1 fixed, pass 3 strip over fixed; both use a ctrl value they must ignore
    for (int m = 0; m < 4; m++) begin
      c = (m == 2) ? 16'h4080 : (m == 3) ? 16'hC0C0 : 16'h8040;
      mode_w = (m == 1) ? (32'h1 << MODE_FIXED_BIT) :
               (m == 3) ? ((32'h1 << MODE_STRIP_BIT) | (32'h1 << MODE_FIXED_BIT)) : 32'h0;
      bus(CTRL_OFFSET, 32'(c), 1'b1, SPACE_ROOT);
      bus(MODE_OFFSET, mode_w, 1'b1, SPACE_ROOT);
      for (int l = 0; l < 4; l++) begin
        e_lab = (m == 3) ? 1'b0 : (m == 1 || l < 2) ? l[0] : (l == 2) ? c[15] : c[7];
        e_flag = (m != 1 && m != 3 && l > 1) && ((l == 2) ? c[14] : c[6]);
        e_pid = (m == 3) ? 16'h0000 : 16'(l * 16'h1111);
        lab_in <= 2'(l);
        pas_in <= 2'(~l);
        pid_in <= 16'(l * 16'h1111);
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        @(posedge mclk);
        chk("valid", 32'h1, 32'(out_valid));
        chk("label", 32'(e_lab), 32'(lab_out));
        chk("flag", 32'(e_flag), 32'(flag));
        chk("pas", 32'(pas_in), 32'(out_pas));
        chk("part_id", 32'(e_pid), 32'(out_pid));
        e_mon += 8'(!e_flag);
      end
    end
    @(posedge mclk);
    chk("monitored", 32'(e_mon), 32'(mon_count));
    // programmable passes carried root and realm requests, so the remap flag must stick
    bus(STATUS_OFFSET, 32'h0, 1'b0, SPACE_ROOT);
    chk("status_remap", 32'h1 << STATUS_REMAP_BIT, rd);
    conclude();
  end
endmodule : tb_four_to_two_space_remapper

// File: test/two_space_sink.sv
// downstream two-space component model counting monitored requests
`timescale 1ns/1ps
module two_space_sink (
  // clock, reset and request
  input wire logic mclk,
  input wire logic reset,
  input wire logic valid,
  input wire logic suppress,
  output logic [7:0] mon_count
);
  // suppressed requests never reach the monitor count
  always_ff @(posedge mclk) begin
    if (reset) begin
      mon_count <= 8'h00;
    end else if (valid && !suppress) begin
      mon_count <= mon_count + 8'h01;
    end
  end
endmodule : two_space_sink
